//--- hw/vrc_top.sv
// Voltage reference control register with AXI4-Lite access
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
module vrc_top #(
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Generator requests from the low-voltage detector and brown-out reset
    input wire logic low_voltage_detector_req,
    input wire logic brownout_reset_req,
    // Generator and reference controls
    output logic gen_power_up,
    output logic high_reference_enable,
    output logic low_reference_enable,
    output logic port_a_line_three_route,
    output logic port_a_line_two_route
);
    // Register address match, used by both the write and the read path
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        addr_hit = (addr[ADDR_W-1:2] == vrc_pkg::VRC_CTRL_ADDR[ADDR_W-1:2]);
    endfunction

    vrc_pkg::vrc_ctrl_t ctrl_q; // Software control bits
    vrc_pkg::vrc_req_t req_raw; // Raw asynchronous requests
    vrc_pkg::vrc_req_t sync1_q, sync2_q, sync3_q; // Three-stage synchronisers
    vrc_pkg::vrc_req_t req_q; // Filtered requests
    vrc_pkg::vrc_req_t req_d;
    logic [ADDR_W-1:0] awaddr_q; // Captured write address
    logic [31:0] wdata_q; // Captured write data
    logic [3:0] wstrb_q;
    logic aw_full_q, w_full_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic power_q, high_q, low_q, route_hi_q, route_lo_q;

    assign req_raw = '{volt_det: low_voltage_detector_req, brownout: brownout_reset_req};

    // Handshake decode
    wire aw_take = s_axi_awvalid & awready_q;
    wire w_take = s_axi_wvalid & wready_q;
    wire ar_take = s_axi_arvalid & arready_q;
    wire do_write = aw_full_q & w_full_q & ~bvalid_q;
    wire aw_full_d = (aw_full_q & ~do_write) | aw_take;
    wire w_full_d = (w_full_q & ~do_write) | w_take;
    wire bvalid_d = (bvalid_q & ~s_axi_bready) | do_write;
    wire rvalid_d = (rvalid_q & ~s_axi_rready) | ar_take;
    wire wr_hit = addr_hit(awaddr_q);
    wire rd_hit = addr_hit(s_axi_araddr);
    // Only byte lane 0 holds the control byte
    wire ctrl_we = do_write & wr_hit & wstrb_q[0];
    // Read word: control bits in the top nibble of byte 0, the rest zero
    wire [31:0] ctrl_word = {24'h00_0000, ctrl_q, 4'h0};
    wire [31:0] rdata_d = rd_hit ? ctrl_word : vrc_pkg::VRC_ZERO_WORD;
    wire [1:0] rresp_d = rd_hit ? vrc_pkg::VRC_RESP_OKAY : vrc_pkg::VRC_RESP_SLVERR;
    wire [1:0] bresp_d = wr_hit ? vrc_pkg::VRC_RESP_OKAY : vrc_pkg::VRC_RESP_SLVERR;
    // Generator stays up while any requester wants it
    wire power_d = ctrl_q.high_en | ctrl_q.low_en | req_q.volt_det | req_q.brownout;
    // Pin routes need both the output enable and the reference enable
    wire route_hi_d = ctrl_q.high_oe & ctrl_q.high_en;
    wire route_lo_d = ctrl_q.low_oe & ctrl_q.low_en;

    // Synchronise each request; a change counts once stages two and three agree
    for (genvar i = 0; i < 2; i++) begin : g_sync
        assign req_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : req_q[i];
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
                sync3_q[i] <= 1'b0;
                req_q[i] <= 1'b0;
            end else begin
                sync1_q[i] <= req_raw[i];
                sync2_q[i] <= sync1_q[i];
                sync3_q[i] <= sync2_q[i];
                req_q[i] <= req_d[i];
            end
        end
    end

    // Write channel capture; each side is held until the write is done
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= '0;
            wdata_q <= vrc_pkg::VRC_ZERO_WORD;
            wstrb_q <= 4'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q <= ~w_full_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response; an unmapped address is answered with an error
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= vrc_pkg::VRC_RESP_OKAY;
        end else begin
            bvalid_q <= bvalid_d;
            if (do_write) begin
                bresp_q <= bresp_d;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= vrc_pkg::VRC_CTRL_RESET;
        end else if (ctrl_we) begin
            ctrl_q.high_en <= wdata_q[vrc_pkg::VRC_HIGH_EN_BIT];
            ctrl_q.low_en <= wdata_q[vrc_pkg::VRC_LOW_EN_BIT];
            ctrl_q.high_oe <= wdata_q[vrc_pkg::VRC_HIGH_OE_BIT];
            ctrl_q.low_oe <= wdata_q[vrc_pkg::VRC_LOW_OE_BIT];
        end
    end

    // read path returns zero below bit 4
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
            rdata_q <= vrc_pkg::VRC_ZERO_WORD;
            rresp_q <= vrc_pkg::VRC_RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            arready_q <= ~rvalid_d;
            if (ar_take) begin
                rdata_q <= rdata_d;
                rresp_q <= rresp_d;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            power_q <= 1'b0;
            high_q <= 1'b0;
            low_q <= 1'b0;
            route_hi_q <= 1'b0;
            route_lo_q <= 1'b0;
        end else begin
            power_q <= power_d;
            high_q <= ctrl_q.high_en;
            low_q <= ctrl_q.low_en;
            route_hi_q <= route_hi_d;
            route_lo_q <= route_lo_d;
        end
    end

    // Every output comes straight from a flip-flop
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign gen_power_up = power_q;
    assign high_reference_enable = high_q;
    assign low_reference_enable = low_q;
    assign port_a_line_three_route = route_hi_q;
    assign port_a_line_two_route = route_lo_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    high_power_up_a: assert property (ctrl_q.high_en |=> power_q && high_q)
        else $error("high enable did not power up generator");
    high_power_down_a: assert property (
        !ctrl_q.high_en && !ctrl_q.low_en && !req_q.volt_det && !req_q.brownout |=> !power_q)
        else $error("generator stayed up with no requester");
    low_power_up_a: assert property (ctrl_q.low_en |=> power_q && low_q)
        else $error("low enable did not power up generator");
    held_by_others_a: assert property (
        !ctrl_q.low_en && (req_q.volt_det || req_q.brownout) |=> power_q)
        else $error("generator dropped while detector requested it");
    high_route_a: assert property (route_hi_q == (high_q && $past(ctrl_q.high_oe)))
        else $error("high pin route wrong");
    low_route_a: assert property (route_lo_q == (low_q && $past(ctrl_q.low_oe)))
        else $error("low pin route without both enables");
    read_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[3:0] == 4'h0)
        else $error("unimplemented bits read non-zero");
    write_store_a: assert property (ctrl_we |=> ctrl_q == $past(wdata_q[7:4]))
        else $error("control bits not stored from the write");
    write_resp_a: assert property (do_write |=> bvalid_q [*1] ##0 !aw_full_q)
        else $error("write response missing");

    write_hit_c: cover property (ctrl_we && wdata_q[vrc_pkg::VRC_HIGH_EN_BIT]);
    read_hit_c: cover property (ar_take && rd_hit);
    both_route_c: cover property (route_hi_q && route_lo_q);
    det_hold_c: cover property (power_q && !ctrl_q.high_en && !ctrl_q.low_en);
endmodule

//--- hw/vrc_pkg.sv
// Shared constants and types for the voltage reference control block
package vrc_pkg;
    // Register index as printed; the byte address is four times it
    localparam logic [11:0] VRC_CTRL_INDEX = 12'h09B;
    localparam logic [11:0] VRC_CTRL_ADDR = 12'h26C;
    // Field positions inside the control byte
    localparam int VRC_HIGH_EN_BIT = 7;
    localparam int VRC_LOW_EN_BIT = 6;
    localparam int VRC_HIGH_OE_BIT = 5;
    localparam int VRC_LOW_OE_BIT = 4;
    // Bus answer codes
    localparam logic [1:0] VRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] VRC_RESP_SLVERR = 2'h2;
    // Read value of all unimplemented and unused positions
    localparam logic [31:0] VRC_ZERO_WORD = 32'h0000_0000;
    localparam logic [3:0] VRC_CTRL_RESET = 4'h0;

    // The four implemented control bits, top bit first
    typedef struct packed {
        logic high_en;
        logic low_en;
        logic high_oe;
        logic low_oe;
    } vrc_ctrl_t;

    // Requests from the neighbouring supervisors
    typedef struct packed {
        logic volt_det; // Low-voltage detector wants the generator
        logic brownout; // Brown-out reset wants the generator
    } vrc_req_t;
endpackage

//--- sim/tb_top.sv
// Self-checking bench for the voltage reference control register
`timescale 1ns/10ps
module tb_top;
    // Bench-driven inputs, all given a value at time zero
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic det_req = 1'b0, brown_req = 1'b0;
    // Design outputs
    logic awready, wready, bvalid, arready, rvalid, pwr, hen, len, rt3, rt2;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] data;
    logic [1:0] resp;
    int bad_count = 0;
    int check_count = 0;
    // Control outputs gathered: power, high, low, line three, line two
    wire [4:0] outs = {pwr, hen, len, rt3, rt2};
    localparam logic [11:0] CTRL = vrc_pkg::VRC_CTRL_ADDR;
    // Rows: byte written, {detector, brown-out}, expected outputs
    logic [7:0] row_wr [12] = '{8'h80, 8'hA0, 8'h20, 8'h40, 8'h50, 8'h10,
                               8'h00, 8'h00, 8'hFF, 8'h0F, 8'hC0, 8'h00};
    logic [1:0] row_rq [12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
                               2'h2, 2'h1, 2'h0, 2'h0, 2'h3, 2'h0};
    logic [4:0] row_ex [12] = '{5'h18, 5'h1A, 5'h00, 5'h14, 5'h15, 5'h00,
                               5'h10, 5'h10, 5'h1F, 5'h00, 5'h1C, 5'h00};

    vrc_top i_dut (
        .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .low_voltage_detector_req(det_req), .brownout_reset_req(brown_req), .gen_power_up(pwr),
        .high_reference_enable(hen), .low_reference_enable(len),
        .port_a_line_three_route(rt3), .port_a_line_two_route(rt2)
    );

    // Free-running core clock, 20 ns period
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Compare and count; unknowns never match
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        bit done;
        done = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1;
            end
        end
    endtask

    // Read: address held until taken, rready held until data arrives
    task automatic rd(input logic [11:0] a);
        bit done;
        done = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1;
            end
        end
    endtask

    // Closing verdict, reached from the main sequence or the watchdog
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        bad_count++;
        results();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk("outputs after reset", 32'h0, {27'h0, outs});
        rd(CTRL);
        chk("control after reset", 32'h0, data);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            {det_req, brown_req} <= row_rq[i];
            wr(CTRL, {24'h0, row_wr[i]}, 4'hF);
            chk("write response", {30'h0, vrc_pkg::VRC_RESP_OKAY}, {30'h0, resp});
            repeat (6) @(posedge ref_clk);
            #1 chk("outputs", {27'h0, row_ex[i]}, {27'h0, outs});
            rd(CTRL);
            chk("readback", {24'h0, row_wr[i] & 8'hF0}, data);
            $display("row %0d done", i);
        end
        wr(CTRL, 32'h0000_00F0, 4'hF);
        wr(CTRL, 32'h0000_0000, 4'h0);
        rd(CTRL);
        chk("strobe-off write", 32'h0000_00F0, data);
        wr(12'h000, 32'h0000_0000, 4'hF);
        chk("unmapped write response", {30'h0, vrc_pkg::VRC_RESP_SLVERR}, {30'h0, resp});
        rd(12'h000);
        chk("unmapped read response", {30'h0, vrc_pkg::VRC_RESP_SLVERR}, {30'h0, resp});
        chk("unmapped read data", 32'h0, data);
        rd(CTRL);
        chk("control after unmapped write", 32'h0000_00F0, data);
        $display("awkward access test done");
        // Second reset mid-run clears every control bit
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk("outputs in reset", 32'h0, {27'h0, outs});
        // Release on a rising edge like every other stimulus
        @(posedge ref_clk);
        rst <= 1'b0;
        rd(CTRL);
        chk("control after second reset", 32'h0, data);
        $display("mid-run reset test done");
        results();
    end
endmodule
